// *** core/scm_pkg.sv ***
// What this block does
// - latch endian strap into config bit 10; 0 big, 1 little endian
// - latch eeprom data strap into config bit 9; 1 means eeprom fitted
// - config bit 7 reads 1 only in 8-bit host bus mode
// - config bit 6 reads 1 only in 16-bit host bus mode
// - config bit 4 reads 1 when address and data share bus lines
// - config bit 1 reads 1 for the 48-pin package
// - config register read-only; bits 8,5,3,2,0 read zero
// - after reset load three mac registers from eeprom starting at word 1
// - word 1 to low, word 2 to middle, word 3 to high mac register
// - host mac writes change registers only, never the eeprom
// - low mac register is 16-bit read/write, least significant word
// - write-one-to-clear bits clear on 1, unchanged on 0
// - read/write-any-clear bits read current value, any write to the high byte clears
// - read/write bits return last written value
// - phy basic control at 0xe4, reset 0x3120
// - phy basic status at 0xe6, reset 0x7808
// - phy identifier low at 0xe8, high at 0xea, fixed values
// - autoneg advertisement at 0xec, reset 0x05e1
// - autoneg partner ability at 0xee, reset 0x0001
// - port control at 0xf6 reset 0x00ff; special control at 0xf4 reset 0
// - port status at 0xf8, reset 0x8080
// - mac auto-load only with eeprom present, else software programs it
package scm_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_CFG     = 8'h08;
  localparam logic [7:0] OFF_MAC_LO  = 8'h10;
  localparam logic [7:0] OFF_MAC_MID = 8'h12;
  localparam logic [7:0] OFF_MAC_HI  = 8'h14;
  localparam logic [7:0] OFF_PCTL    = 8'he4;
  localparam logic [7:0] OFF_PSTAT   = 8'he6;
  localparam logic [7:0] OFF_IDL     = 8'he8;
  localparam logic [7:0] OFF_IDH     = 8'hea;
  localparam logic [7:0] OFF_ANAR    = 8'hec;
  localparam logic [7:0] OFF_ANLP    = 8'hee;
  localparam logic [7:0] OFF_SPEC    = 8'hf4;
  localparam logic [7:0] OFF_PORTC   = 8'hf6;
  localparam logic [7:0] OFF_PORTS   = 8'hf8;
  // ==========================================================
  // reset values
  localparam logic [15:0] RST_PCTL  = 16'h3120;
  localparam logic [15:0] RST_PSTAT = 16'h7808;
  localparam logic [15:0] RST_ANAR  = 16'h05e1;
  localparam logic [15:0] RST_ANLP  = 16'h0001;
  localparam logic [15:0] RST_SPEC  = 16'h0000;
  localparam logic [15:0] RST_PORTC = 16'h00ff;
  localparam logic [15:0] RST_PORTS = 16'h8080;
  localparam logic [15:0] RST_MAC   = 16'h0000;
  // ==========================================================
  // field positions
  localparam int CFG_ENDIAN = 10;
  localparam int CFG_EE     = 9;
  localparam int CFG_BUS8   = 7;
  localparam int CFG_BUS16  = 6;
  localparam int CFG_SHARED = 4;
  localparam int CFG_PKG48  = 1;
  localparam logic [15:0] CFG_RSVD_MASK = 16'hf92d;
  localparam int SPEC_W1C   = 15;
  localparam int SPEC_WAC   = 14;
  localparam logic [15:0] SPEC_RW_MASK = 16'h3fff;
  // ==========================================================
  // eeprom and timing
  localparam logic [1:0] EE_FIRST_WORD = 2'h1;
  localparam logic [1:0] EE_LAST_WORD  = 2'h3;
  localparam logic [1:0] STRAP_SETTLE  = 2'h3;
  // ==========================================================
  // types
  typedef enum logic [1:0] {PH_SETTLE, PH_LOAD, PH_READY} scm_phase_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } scm_bus_req_t;
  typedef struct packed {
    logic endian;
    logic ee;
    logic width16;
    logic shared;
    logic pkg48;
  } scm_strap_t;
  typedef struct packed {
    logic       req;
    logic [7:0] addr;
  } scm_ee_req_t;
  typedef struct packed {
    logic        ack;
    logic [15:0] data;
  } scm_ee_rsp_t;
  typedef struct packed {
    scm_strap_t        s1;
    scm_strap_t        s2;
    scm_strap_t        s3;
    scm_strap_t        cap;
    logic [1:0]        cnt;
    scm_phase_t        phase;
    logic [1:0]        word;
    logic [2:0][15:0]  mac;
    logic [15:0]       pctl;
    logic [15:0]       anar;
    logic [15:0]       spec;
    logic [15:0]       portc;
    logic [15:0]       rdata;
  } scm_state_t;
endpackage : scm_pkg

// *** core/scm_regs.sv ***
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module scm_regs #(
  parameter logic [15:0] PHY_ID_LOW  = 16'h0a5a, // arbitrary value
  parameter logic [15:0] PHY_ID_HIGH = 16'h00c3  // arbitrary value
) (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  sys_rst_in,
  // host register port
  input  wire scm_pkg::scm_bus_req_t bus_in,
  output logic [15:0]                rdata_out,
  // strap pins
  input  wire scm_pkg::scm_strap_t   strap_in,
  // eeprom word reader
  output scm_pkg::scm_ee_req_t       ee_req_out,
  input  wire scm_pkg::scm_ee_rsp_t  ee_rsp_in,
  // phy events
  input  wire logic                  diag_done_in,
  input  wire logic                  link_chg_in,
  // to the rest of the chip
  output logic [47:0]                mac_addr_out,
  output logic [15:0]                phy_ctrl_out,
  output logic [15:0]                phy_anar_out,
  output logic [15:0]                port_ctrl_out,
  output logic                       ready_out
);
  import scm_pkg::*;

  scm_state_t  s_ff;
  scm_state_t  nxt_s;
  logic [15:0] cfg;
  logic        bus8;
  logic [7:0]  woff;
  logic [1:0]  be;
  logic [15:0] wd;
  logic [15:0] rword;
  logic        ee_take;

  // ==========================================================
  // helpers
  function automatic logic [15:0] scm_merge(input logic [15:0] old,
                                            input logic [15:0] d,
                                            input logic [1:0]  en);
    return {en[1] ? d[15:8] : old[15:8], en[0] ? d[7:0] : old[7:0]};
  endfunction : scm_merge

  function automatic logic [7:0] scm_word(input logic [7:0] a);
    return {a[7:1], 1'b0};
  endfunction : scm_word

  // ==========================================================
  // configuration word
  always_comb begin
    cfg             = '0;
    cfg[CFG_ENDIAN] = s_ff.cap.endian;
    cfg[CFG_EE]     = s_ff.cap.ee;
    cfg[CFG_BUS8]   = ~s_ff.cap.width16;
    cfg[CFG_BUS16]  = s_ff.cap.width16;
    cfg[CFG_SHARED] = s_ff.cap.shared;
    cfg[CFG_PKG48]  = s_ff.cap.pkg48;
  end

  // ==========================================================
  // byte lanes
  assign bus8 = ~s_ff.cap.width16;
  assign woff = scm_word(bus_in.addr);
  always_comb begin
    if (bus8) begin
      be = bus_in.addr[0] ? 2'b10 : 2'b01;
      wd = {bus_in.wdata[7:0], bus_in.wdata[7:0]};
    end else begin
      be = 2'b11;
      wd = bus_in.wdata;
    end
  end

  // ==========================================================
  // read mux
  always_comb begin
    unique case (woff)
      OFF_CFG:     rword = cfg;
      OFF_MAC_LO:  rword = s_ff.mac[0];
      OFF_MAC_MID: rword = s_ff.mac[1];
      OFF_MAC_HI:  rword = s_ff.mac[2];
      OFF_PCTL:    rword = s_ff.pctl;
      OFF_PSTAT:   rword = RST_PSTAT;
      OFF_IDL:     rword = PHY_ID_LOW;
      OFF_IDH:     rword = PHY_ID_HIGH;
      OFF_ANAR:    rword = s_ff.anar;
      OFF_ANLP:    rword = RST_ANLP;
      OFF_SPEC:    rword = s_ff.spec;
      OFF_PORTC:   rword = s_ff.portc;
      OFF_PORTS:   rword = RST_PORTS;
      default:     rword = '0;
    endcase
  end

  // ==========================================================
  // eeprom reader
  assign ee_take          = (s_ff.phase == PH_LOAD) && ee_rsp_in.ack;
  assign ee_req_out.req   = (s_ff.phase == PH_LOAD);
  assign ee_req_out.addr  = {6'h00, s_ff.word};

  // ==========================================================
  // next state
  always_comb begin
    nxt_s    = s_ff;
    nxt_s.s1 = strap_in;
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    // strap capture after reset release
    unique case (s_ff.phase)
      PH_SETTLE: begin
        if (s_ff.cnt != STRAP_SETTLE) begin
          nxt_s.cnt = s_ff.cnt + 2'h1;
        end else if (s_ff.s2 == s_ff.s3) begin
          nxt_s.cap   = s_ff.s3;
          nxt_s.phase = s_ff.s3.ee ? PH_LOAD : PH_READY;
        end
      end
      PH_LOAD: begin
        if (ee_rsp_in.ack) begin
          nxt_s.word = s_ff.word + 2'h1;
          if (s_ff.word == EE_LAST_WORD) begin
            nxt_s.phase = PH_READY;
          end
        end
      end
      PH_READY: begin
      end
    endcase
    // host writes, registers only
    if (bus_in.wr) begin
      unique case (woff)
        OFF_MAC_LO:  nxt_s.mac[0] = scm_merge(s_ff.mac[0], wd, be);
        OFF_MAC_MID: nxt_s.mac[1] = scm_merge(s_ff.mac[1], wd, be);
        OFF_MAC_HI:  nxt_s.mac[2] = scm_merge(s_ff.mac[2], wd, be);
        OFF_PCTL:    nxt_s.pctl   = scm_merge(s_ff.pctl, wd, be);
        OFF_ANAR:    nxt_s.anar   = scm_merge(s_ff.anar, wd, be);
        OFF_PORTC:   nxt_s.portc  = scm_merge(s_ff.portc, wd, be);
        OFF_SPEC: begin
          nxt_s.spec = (s_ff.spec & ~SPEC_RW_MASK)
                     | (scm_merge(s_ff.spec, wd, be) & SPEC_RW_MASK);
          if (be[1] && wd[SPEC_W1C]) begin
            nxt_s.spec[SPEC_W1C] = 1'b0;
          end
          if (be[1]) begin
            nxt_s.spec[SPEC_WAC] = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // hardware sets win over clears
    if (diag_done_in) begin
      nxt_s.spec[SPEC_W1C] = 1'b1;
    end
    if (link_chg_in) begin
      nxt_s.spec[SPEC_WAC] = 1'b1;
    end
    // eeprom load wins over a host write
    if (ee_take) begin
      nxt_s.mac[s_ff.word - EE_FIRST_WORD] = ee_rsp_in.data;
    end
    // read data one cycle later only
    nxt_s.rdata = '0;
    if (bus_in.rd) begin
      if (bus8) begin
        nxt_s.rdata = {8'h00, bus_in.addr[0] ? rword[15:8] : rword[7:0]};
      end else begin
        nxt_s.rdata = rword;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_ff       <= '0;
      s_ff.phase <= PH_SETTLE;
      s_ff.word  <= EE_FIRST_WORD;
      s_ff.mac   <= {RST_MAC, RST_MAC, RST_MAC};
      s_ff.pctl  <= RST_PCTL;
      s_ff.anar  <= RST_ANAR;
      s_ff.spec  <= RST_SPEC;
      s_ff.portc <= RST_PORTC;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // outputs
  assign rdata_out     = s_ff.rdata;
  assign mac_addr_out  = {s_ff.mac[2], s_ff.mac[1], s_ff.mac[0]};
  assign phy_ctrl_out  = s_ff.pctl;
  assign phy_anar_out  = s_ff.anar;
  assign port_ctrl_out = s_ff.portc;
  assign ready_out     = (s_ff.phase == PH_READY);

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_cfg_rsvd_zero: assert property (
    $past(bus_in.rd) && !bus8 && scm_word($past(bus_in.addr)) == OFF_CFG
    |-> ((rdata_out & CFG_RSVD_MASK) == 16'h0000 &&
         rdata_out[CFG_ENDIAN] == s_ff.cap.endian &&
         rdata_out[CFG_EE] == s_ff.cap.ee))
    else $error("config read shows wrong bits");

  a_width_one_hot: assert property (
    $past(bus_in.rd) && $past(bus_in.addr) == OFF_CFG
    |-> rdata_out[CFG_BUS8] == $past(bus8) && rdata_out[CFG_BUS16] == !$past(bus8))
    else $error("bus width bits not exclusive");

  a_load_needs_ee: assert property (
    ee_req_out.req |-> s_ff.cap.ee)
    else $error("eeprom read without eeprom");

  a_mac_word_map: assert property (
    ee_take && s_ff.word == EE_FIRST_WORD
    |=> s_ff.mac[0] == $past(ee_rsp_in.data))
    else $error("eeprom word 1 not in low mac");

  a_load_ends: assert property (
    ee_take && s_ff.word == EE_LAST_WORD |=> ready_out && !ee_req_out.req)
    else $error("load did not end after word 3");

  a_w1c_clear: assert property (
    bus_in.wr && !bus8 && woff == OFF_SPEC && !diag_done_in
    |=> s_ff.spec[SPEC_W1C] == ($past(s_ff.spec[SPEC_W1C])
                                && !$past(bus_in.wdata[SPEC_W1C])))
    else $error("write-one-to-clear misbehaves");

  a_wac_clear: assert property (
    bus_in.wr && !bus8 && woff == OFF_SPEC && !link_chg_in
    |=> !s_ff.spec[SPEC_WAC])
    else $error("any-write clear misbehaves");

  a_set_wins: assert property (
    link_chg_in ##0 diag_done_in |=> s_ff.spec[SPEC_WAC] && s_ff.spec[SPEC_W1C])
    else $error("hardware set lost");

  a_rw_readback: assert property (
    bus_in.wr && !bus8 && woff == OFF_PORTC ##1 bus_in.rd && !bus_in.wr
    && woff == OFF_PORTC |=> rdata_out == $past(bus_in.wdata, 2))
    else $error("port control readback wrong");

  a_rdata_quiet: assert property (
    !$past(bus_in.rd) |-> rdata_out == 16'h0000)
    else $error("read data outside its cycle");

  a_byte_lane: assert property (
    $past(bus_in.rd) && bus8 |-> rdata_out[15:8] == 8'h00)
    else $error("byte mode upper lane not zero");

  a_status_const: assert property (
    $past(bus_in.rd) && !bus8 && scm_word($past(bus_in.addr)) == OFF_PSTAT
    |-> rdata_out == RST_PSTAT)
    else $error("phy status wrong");
endmodule : scm_regs

// *** testbench/scm_ee_model.sv ***
`timescale 1ns/1ps
module scm_ee_model (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 sys_rst_in,
  // word reader
  input  wire scm_pkg::scm_ee_req_t req_in,
  output scm_pkg::scm_ee_rsp_t      rsp_out
);
  import scm_pkg::*;
  // ==========================================================
  // word store and answer timing
  logic [1:0] cnt_ff;
  function automatic logic [15:0] word_at(input logic [7:0] a);
    case (a)
      8'h01:   word_at = 16'h89ab;
      8'h02:   word_at = 16'h4567;
      8'h03:   word_at = 16'h0123;
      default: word_at = 16'hdead;
    endcase
  endfunction : word_at
  // word 1 answers at once, later words wait three cycles
  always_ff @(posedge clk_in) begin
    rsp_out.ack  <= 1'b0;
    rsp_out.data <= ~rsp_out.data;
    if (sys_rst_in) begin
      cnt_ff       <= 2'h0;
      rsp_out.data <= 16'h0000;
    end else if (req_in.req && !rsp_out.ack) begin
      if (req_in.addr == 8'h01 || cnt_ff == 2'h3) begin
        rsp_out.ack  <= 1'b1;
        rsp_out.data <= word_at(req_in.addr);
        cnt_ff       <= 2'h0;
      end else begin
        cnt_ff <= cnt_ff + 2'h1;
      end
    end
  end
endmodule : scm_ee_model

// *** testbench/test_scm_regs.sv ***
`timescale 1ns/1ps
module test_scm_regs;
  import scm_pkg::*;
  // ==========================================================
  // signals
  logic         clk_in     = 1'b0;
  logic         sys_rst_in = 1'b1;
  scm_bus_req_t bus        = '0;
  scm_strap_t   strap      = '{endian: 1'b1, ee: 1'b1, width16: 1'b1, shared: 1'b0, pkg48: 1'b1};
  logic         diag       = 1'b0;
  logic         link       = 1'b0;
  logic [15:0]  rdata, pctl, anar, portc, d;
  logic [47:0]  mac;
  logic         ready;
  scm_ee_req_t  ee_req;
  scm_ee_rsp_t  ee_rsp;
  int           failures    = 0;
  int           comparisons = 0;
  logic [7:0]   offs [9] = '{8'he4, 8'he6, 8'he8, 8'hea, 8'hec, 8'hee, 8'hf4, 8'hf6, 8'hf8};
  logic [15:0]  vals [9] = '{16'h3120, 16'h7808, 16'h5a5a, 16'h3c3c, 16'h05e1, 16'h0001,
                             16'h0000, 16'h00ff, 16'h8080};
  // ==========================================================
  // design and eeprom
  scm_regs #(.PHY_ID_LOW(16'h5a5a), .PHY_ID_HIGH(16'h3c3c)) DUT ( // arbitrary id values
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus_in(bus), .rdata_out(rdata),
    .strap_in(strap), .ee_req_out(ee_req), .ee_rsp_in(ee_rsp), .diag_done_in(diag),
    .link_chg_in(link), .mac_addr_out(mac), .phy_ctrl_out(pctl), .phy_anar_out(anar),
    .port_ctrl_out(portc), .ready_out(ready));
  scm_ee_model EE (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_in(ee_req), .rsp_out(ee_rsp));
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
    chk({32'h0, d}, {32'h0, exp});
  endtask : rc
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] v, input logic [15:0] exp);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
    chk({32'h0, d}, {32'h0, exp});
  endtask : wr_rd
  task automatic wait_ready();
    for (int i = 0; i < 200 && ready !== 1'b1; i++) @(posedge clk_in);
    #1;
    chk({47'h0, ready}, 48'h1);
  endtask : wait_ready
  task automatic final_report();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  // ==========================================================
  // tests
  initial begin
    #(20 * 20000);
    failures++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    wait_ready();
    rc(OFF_CFG, 16'h0642);
    chk(mac, 48'h0123_4567_89ab);
    rc(OFF_MAC_LO, 16'h89ab);
    rc(OFF_MAC_MID, 16'h4567);
    rc(OFF_MAC_HI, 16'h0123);
    for (int i = 0; i < 9; i++) rc(offs[i], vals[i]);
    chk({32'h0, pctl}, 48'h3120);
    chk({32'h0, anar}, 48'h05e1);
    wr(OFF_CFG, 16'hffff);
    wr(OFF_PSTAT, 16'h0000);
    wr(8'h40, 16'hffff);
    rc(OFF_CFG, 16'h0642);
    rc(OFF_PSTAT, 16'h7808);
    rc(8'h40, 16'h0000);
    wr(OFF_PORTC, 16'h1234);
    rc(OFF_PORTC, 16'h1234);
    chk({32'h0, portc}, 48'h1234);
    wr_rd(OFF_PORTC, 16'h5678, 16'h5678);
    chk({32'h0, portc}, 48'h5678);
    wr(OFF_MAC_LO, 16'hbeef);
    rc(OFF_MAC_LO, 16'hbeef);
    chk({47'h0, ee_req.req}, 48'h0);
    chk({32'h0, mac[15:0]}, 48'hbeef);
    @(posedge clk_in);
    diag <= 1'b1;
    link <= 1'b1;
    @(posedge clk_in);
    diag <= 1'b0;
    link <= 1'b0;
    rc(OFF_SPEC, 16'hc000);
    wr(OFF_SPEC, 16'h0123);
    rc(OFF_SPEC, 16'h8123);
    wr(OFF_SPEC, 16'h8000);
    rc(OFF_SPEC, 16'h0000);
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    strap      <= '{endian: 1'b0, ee: 1'b0, width16: 1'b0, shared: 1'b1, pkg48: 1'b0};
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    wait_ready();
    rc(OFF_CFG, 16'h0090);
    rc(8'h09, 16'h0000);
    chk(mac, 48'h0);
    chk({47'h0, ee_req.req}, 48'h0);
    wr(OFF_PORTC, 16'h0034);
    wr(8'hf7, 16'h0012);
    rc(OFF_PORTC, 16'h0034);
    rc(8'hf7, 16'h0012);
    chk({32'h0, portc}, 48'h1234);
    rc(8'he5, 16'h0031);
    @(posedge clk_in);
    diag <= 1'b1;
    link <= 1'b1;
    @(posedge clk_in);
    diag <= 1'b0;
    link <= 1'b0;
    wr(OFF_SPEC, 16'h0080);
    rc(8'hf5, 16'h00c0);
    rc(OFF_SPEC, 16'h0080);
    wr(8'hf5, 16'h0080);
    rc(8'hf5, 16'h0000);
    rc(OFF_SPEC, 16'h0080);
    final_report();
  end
endmodule : test_scm_regs
